// ===== shared/abex_pkg.sv
// abex_pkg: constants and types of the ALU and branch execute unit.
// Assumes a fetch stage that hands over decoded operations as abex_op_e.
package abex_pkg;
  // ==========================================================
  // Sizes
  localparam int REG_NUM  = 32;
  localparam int PC_W_DEF = 10;
  localparam int OFFS_W   = 12;
  // ==========================================================
  // Status register bit positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] ALL_ONES   = 8'hff;
  localparam logic [7:0] DATA_ZERO  = 8'h00;
  localparam logic [7:0] DATA_ONE   = 8'h01;
  localparam logic [4:0] ZPTR_LO    = 5'h1e;
  localparam logic [4:0] ZPTR_HI    = 5'h1f;
  // Flags touched per class: arith Z,C,N,V,H; word Z,C,N,V,S; logic Z,N,V
  localparam logic [7:0] MASK_ARITH = 8'h2f;
  localparam logic [7:0] MASK_WORD  = 8'h1f;
  localparam logic [7:0] MASK_LOGIC = 8'h0e;
  localparam logic [7:0] MASK_COMPL = 8'h0f;
  localparam logic [7:0] MASK_NONE  = 8'h00;
  // ==========================================================
  // Cycle counts
  localparam logic [2:0] CYC_ONE   = 3'h1;
  localparam logic [2:0] CYC_WORD  = 3'h2;
  localparam logic [2:0] CYC_JUMP  = 3'h2;
  localparam logic [2:0] CYC_CALL  = 3'h3;
  localparam logic [2:0] CYC_RET   = 3'h4;
  localparam logic [2:0] CYC_TAKEN = 3'h2;
  localparam logic [2:0] CYC_SKIP1 = 3'h2;
  localparam logic [2:0] CYC_SKIP2 = 3'h3;
  // ==========================================================
  // Decoded operations
  typedef enum logic [5:0] {
    OP_ADD, OP_ADD_CARRY, OP_WORD_ADD_IMMEDIATE, OP_SUB,
    OP_SUB_CONSTANT, OP_WORD_SUB_IMMEDIATE, OP_SUB_WITH_CARRY,
    OP_SUB_CONST_WITH_CARRY, OP_AND, OP_AND_CONSTANT, OP_OR,
    OP_OR_CONSTANT, OP_EXCLUSIVE_OR_OP, OP_ONES_COMPLEMENT,
    OP_TWOS_COMPLEMENT_OP, OP_SET_BITS_OP, OP_CLEAR_BITS_OP,
    OP_INCREMENT, OP_DECREMENT, OP_ZERO_MINUS_TEST, OP_CLEAR_REG,
    OP_SET_ALL_ONES, OP_RELATIVE_JUMP, OP_POINTER_JUMP,
    OP_RELATIVE_CALL, OP_POINTER_CALL, OP_SUB_RETURN,
    OP_INTERRUPT_RETURN, OP_COMPARE_SKIP_EQUAL, OP_COMPARE,
    OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE,
    OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR,
    OP_SKIP_IO_BIT_SET, OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR,
    OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT, OP_BRANCH_UNSIGNED_HS,
    OP_BRANCH_UNSIGNED_LO, OP_BRANCH_HALFCARRY_SET,
    OP_BRANCH_HALFCARRY_CLEAR, OP_BRANCH_IRQ_ENABLED,
    OP_BRANCH_IRQ_DISABLED, OP_BRANCH_COPYFLAG_SET,
    OP_BRANCH_COPYFLAG_CLEAR, OP_BRANCH_OVERFLOW_SET,
    OP_BRANCH_OVERFLOW_CLEAR
  } abex_op_e;
  // Sequencer states
  typedef enum logic {ST_ISSUE, ST_WAIT} abex_state_e;
endpackage

// ===== design/abex_alu8.sv
// abex_alu8: 8-bit adder/subtractor with carry, half-carry, overflow.
// Assumes operands come from the execute unit on the same clock.
`timescale 1ns/100ps
`default_nettype none
module abex_alu8 (
  // Operands
  input  wire logic       i_sub,
  input  wire logic [7:0] i_a,
  input  wire logic [7:0] i_b,
  input  wire logic       i_cin,
  // Result and flags
  output logic [7:0]      o_res,
  output logic            o_carry,
  output logic            o_half,
  output logic            o_ovf
);
  // ==========================================================
  // Subtraction as a + ~b + ~borrow, so one adder serves both
  logic [7:0] b_eff;
  logic       c_eff;
  logic [8:0] full;
  logic [4:0] low;
  assign b_eff = i_sub ? ~i_b : i_b;
  assign c_eff = i_sub ? ~i_cin : i_cin;
  assign full  = {1'b0, i_a} + {1'b0, b_eff} + {8'h00, c_eff};
  assign low   = {1'b0, i_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
  // Carry-out becomes a borrow when subtracting
  assign o_res   = full[7:0];
  assign o_carry = i_sub ? ~full[8] : full[8];
  assign o_half  = i_sub ? ~low[4] : low[4];
  assign o_ovf   = (i_a[7] == b_eff[7]) && (full[7] != i_a[7]);
endmodule
`default_nettype wire

// ===== design/abex_exec.sv
// abex_exec: executes arithmetic, logic, compare, skip and branch work.
// Assumes fetch presents decoded operations and waits on o_instr_ready.
`timescale 1ns/100ps
`default_nettype none
module abex_exec #(
  parameter int PC_W = abex_pkg::PC_W_DEF
) (
  // Clock, reset, enable
  input  wire logic                         i_clock,
  input  wire logic                         i_rst_b,
  input  wire logic                         i_ce,
  // Decoded instruction from fetch
  input  wire logic                         i_instr_valid,
  input  wire abex_pkg::abex_op_e           i_op,
  input  wire logic [4:0]                   i_dst_reg,
  input  wire logic [4:0]                   i_source_register,
  input  wire logic [7:0]                   i_imm,
  input  wire logic [abex_pkg::OFFS_W-1:0]  i_offset,
  input  wire logic [2:0]                   i_bit_sel,
  input  wire logic                         i_next_is_long,
  output logic                              o_instr_ready,
  output logic [PC_W-1:0]                   o_pc,
  // I/O register picked by the skip operand
  input  wire logic [7:0]                   i_io_rdata,
  // Return stack
  output logic                              o_push_valid,
  output logic [PC_W-1:0]                   o_push_word,
  output logic                              o_pop_valid,
  input  wire logic [PC_W-1:0]              i_pop_word,
  // Writes from the data-transfer side
  input  wire logic                         i_load_valid,
  input  wire logic [4:0]                   i_load_reg,
  input  wire logic [7:0]                   i_load_data,
  input  wire logic                         i_status_we,
  input  wire logic [7:0]                   i_status_data,
  // Observation
  input  wire logic [4:0]                   i_peek_reg,
  output logic [7:0]                        o_peek_data,
  output logic [7:0]                        o_status_register
);
  import abex_pkg::*;

  // ==========================================================
  // State
  logic [7:0]      regs_r [REG_NUM];
  logic [7:0]      status_r;
  logic [PC_W-1:0] pc_r;
  abex_state_e     state_r;
  logic [2:0]      wait_r;
  logic            accept;

  // ==========================================================
  // Operands
  logic [7:0]  rd_val;
  logic [7:0]  src_val;
  logic [4:0]  rd_hi;
  logic [15:0] word_val;
  logic [15:0] zptr;
  logic [PC_W-1:0] pc_seq;
  logic [PC_W-1:0] pc_rel;
  assign rd_val   = regs_r[i_dst_reg];
  assign src_val  = regs_r[i_source_register];
  assign rd_hi    = 5'(i_dst_reg + 5'h01);
  assign word_val = {regs_r[rd_hi], rd_val};
  assign zptr     = {regs_r[ZPTR_HI], regs_r[ZPTR_LO]};
  assign pc_seq   = PC_W'(pc_r + 1'b1);
  // Offset wraps modulo the program space, so every word is reachable
  assign pc_rel   = PC_W'(pc_r + PC_W'($signed(i_offset)) + 1'b1);

  // ==========================================================
  // ALU operand steering
  logic       alu_sub;
  logic       alu_cin;
  logic [7:0] alu_a;
  logic [7:0] alu_b;
  logic [7:0] alu_res;
  logic       alu_c;
  logic       alu_h;
  logic       alu_v;

  always_comb begin
    alu_sub = 1'b1;
    alu_cin = 1'b0;
    alu_a   = rd_val;
    alu_b   = src_val;
    unique case (i_op)
      OP_ADD: alu_sub = 1'b0;
      OP_ADD_CARRY: begin
        alu_sub = 1'b0;
        alu_cin = status_r[FLG_C];
      end
      OP_SUB_CONSTANT, OP_COMPARE_IMMEDIATE: alu_b = i_imm;
      OP_SUB_WITH_CARRY, OP_COMPARE_WITH_CARRY:
        alu_cin = status_r[FLG_C];
      OP_SUB_CONST_WITH_CARRY: begin
        alu_b   = i_imm;
        alu_cin = status_r[FLG_C];
      end
      OP_TWOS_COMPLEMENT_OP: begin
        alu_a = DATA_ZERO;
        alu_b = rd_val;
      end
      OP_INCREMENT: begin
        alu_sub = 1'b0;
        alu_b   = DATA_ONE;
      end
      OP_DECREMENT: alu_b = DATA_ONE;
      default: alu_sub = 1'b1;
    endcase
  end

  abex_alu8 u_alu (
    .i_sub   (alu_sub),
    .i_a     (alu_a),
    .i_b     (alu_b),
    .i_cin   (alu_cin),
    .o_res   (alu_res),
    .o_carry (alu_c),
    .o_half  (alu_h),
    .o_ovf   (alu_v)
  );

  // ==========================================================
  // 16-bit pair arithmetic
  logic [16:0] word_sum;
  logic        word_sub;
  logic        word_v;
  logic        word_c;
  assign word_sub = (i_op == OP_WORD_SUB_IMMEDIATE);
  assign word_sum = word_sub ? {1'b0, word_val} - {9'h000, i_imm}
                             : {1'b0, word_val} + {9'h000, i_imm};
  // Pair sign flips the wrong way give overflow; bit 16 is the carry
  assign word_v   = word_sub ? (word_val[15] & ~word_sum[15])
                             : (~word_val[15] & word_sum[15]);
  assign word_c   = word_sum[16];

  // ==========================================================
  // Branch and skip conditions
  logic br_bit;
  logic br_pol;
  logic br_taken;
  logic skip_hit;
  logic is_branch;
  logic is_skip;

  // Branch codes close the enum; the clear variants want the bit low
  always_comb begin
    is_branch = (i_op >= OP_BRANCH_FLAG_SET);
    br_pol    = !(i_op inside {OP_BRANCH_FLAG_CLEAR, OP_BRANCH_SIGNED_GE,
                  OP_BRANCH_UNSIGNED_HS, OP_BRANCH_HALFCARRY_CLEAR,
                  OP_BRANCH_IRQ_DISABLED, OP_BRANCH_COPYFLAG_CLEAR,
                  OP_BRANCH_OVERFLOW_CLEAR});
    unique case (i_op)
      OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT:
        br_bit = status_r[FLG_N] ^ status_r[FLG_V];
      OP_BRANCH_UNSIGNED_HS, OP_BRANCH_UNSIGNED_LO:
        br_bit = status_r[FLG_C];
      OP_BRANCH_HALFCARRY_SET, OP_BRANCH_HALFCARRY_CLEAR:
        br_bit = status_r[FLG_H];
      OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED:
        br_bit = status_r[FLG_I];
      OP_BRANCH_COPYFLAG_SET, OP_BRANCH_COPYFLAG_CLEAR:
        br_bit = status_r[FLG_T];
      OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR:
        br_bit = status_r[FLG_V];
      default: br_bit = status_r[i_bit_sel];
    endcase
  end
  assign br_taken = is_branch && (br_bit == br_pol);

  // Skip tests: equality, register bit or I/O bit
  always_comb begin
    is_skip  = 1'b1;
    skip_hit = 1'b0;
    unique case (i_op)
      OP_COMPARE_SKIP_EQUAL: skip_hit = (rd_val == src_val);
      OP_SKIP_REG_BIT_CLEAR: skip_hit = ~src_val[i_bit_sel];
      OP_SKIP_REG_BIT_SET:   skip_hit = src_val[i_bit_sel];
      OP_SKIP_IO_BIT_CLEAR:  skip_hit = ~i_io_rdata[i_bit_sel];
      OP_SKIP_IO_BIT_SET:    skip_hit = i_io_rdata[i_bit_sel];
      default: is_skip = 1'b0;
    endcase
  end

  // ==========================================================
  // Per-operation result, flags, next PC and cycle count
  logic [7:0]      res8;
  logic            wr8;
  logic            wr16;
  logic [7:0]      fl_new;
  logic [7:0]      fl_mask;
  logic [PC_W-1:0] pc_nxt;
  logic [2:0]      cyc;
  logic            push;
  logic            pop;
  logic            set_i;
  logic            zchain;

  // Register ops lead the enum: they write and touch Z,N,V by default
  always_comb begin
    res8    = alu_res;
    wr8     = (i_op < OP_RELATIVE_JUMP);
    wr16    = 1'b0;
    fl_mask = (i_op < OP_RELATIVE_JUMP) ? MASK_LOGIC : MASK_NONE;
    pc_nxt  = pc_seq;
    cyc     = CYC_ONE;
    push    = 1'b0;
    pop     = 1'b0;
    set_i   = 1'b0;
    zchain  = 1'b0;
    unique case (i_op)
      OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_CONSTANT, OP_TWOS_COMPLEMENT_OP:
        fl_mask = MASK_ARITH;
      OP_SUB_WITH_CARRY, OP_SUB_CONST_WITH_CARRY: begin
        zchain  = 1'b1;
        fl_mask = MASK_ARITH;
      end
      OP_COMPARE, OP_COMPARE_IMMEDIATE:
        fl_mask = MASK_ARITH;
      OP_COMPARE_WITH_CARRY: begin
        zchain  = 1'b1;
        fl_mask = MASK_ARITH;
      end
      OP_WORD_ADD_IMMEDIATE, OP_WORD_SUB_IMMEDIATE: begin
        wr8     = 1'b0;
        wr16    = 1'b1;
        fl_mask = MASK_WORD;
        cyc     = CYC_WORD;
      end
      OP_AND:             res8 = rd_val & src_val;
      OP_ZERO_MINUS_TEST: res8 = rd_val & rd_val;
      OP_AND_CONSTANT:    res8 = rd_val & i_imm;
      OP_OR:              res8 = rd_val | src_val;
      OP_OR_CONSTANT, OP_SET_BITS_OP:
        res8 = rd_val | i_imm;
      OP_EXCLUSIVE_OR_OP: res8 = rd_val ^ src_val;
      OP_CLEAR_BITS_OP:   res8 = rd_val & (ALL_ONES - i_imm);
      OP_ONES_COMPLEMENT: begin
        res8    = ALL_ONES - rd_val;
        fl_mask = MASK_COMPL;
      end
      OP_CLEAR_REG:       res8 = rd_val ^ rd_val;
      OP_SET_ALL_ONES: begin
        res8    = ALL_ONES;
        fl_mask = MASK_NONE;
      end
      OP_RELATIVE_JUMP, OP_RELATIVE_CALL: begin
        pc_nxt = pc_rel;
        push   = (i_op == OP_RELATIVE_CALL);
        cyc    = push ? CYC_CALL : CYC_JUMP;
      end
      OP_POINTER_JUMP, OP_POINTER_CALL: begin
        pc_nxt = PC_W'(zptr);
        push   = (i_op == OP_POINTER_CALL);
        cyc    = push ? CYC_CALL : CYC_JUMP;
      end
      OP_SUB_RETURN, OP_INTERRUPT_RETURN: begin
        pc_nxt = i_pop_word;
        pop    = 1'b1;
        set_i  = (i_op == OP_INTERRUPT_RETURN);
        cyc    = CYC_RET;
      end
      default: begin
        // Also increment and decrement, which keep the defaults
        // Skips and branches: no register write and no flag change
        if (is_skip && skip_hit) begin
          pc_nxt = PC_W'(pc_seq + (i_next_is_long ? 2'h2 : 2'h1));
          cyc    = i_next_is_long ? CYC_SKIP2 : CYC_SKIP1;
        end else if (br_taken) begin
          pc_nxt = pc_rel;
          cyc    = CYC_TAKEN;
        end
      end
    endcase
  end

  // Flag values; the mask decides which of them land
  logic z8;
  logic n8;
  always_comb begin
    z8     = (res8 == DATA_ZERO) && (!zchain || status_r[FLG_Z]);
    n8     = res8[7];
    fl_new = status_r;
    if (wr16) begin
      fl_new[FLG_Z] = (word_sum[15:0] == 16'h0000);
      fl_new[FLG_N] = word_sum[15];
      fl_new[FLG_V] = word_v;
      fl_new[FLG_S] = word_sum[15] ^ word_v;
      fl_new[FLG_C] = word_c;
    end else begin
      fl_new[FLG_Z] = z8;
      fl_new[FLG_N] = n8;
      fl_new[FLG_H] = alu_h;
      fl_new[FLG_C] = alu_c;
      // Logic results clear V; ones complement always sets C
      fl_new[FLG_V] = (fl_mask == MASK_LOGIC &&
                       i_op != OP_INCREMENT &&
                       i_op != OP_DECREMENT) ? 1'b0 :
                      (fl_mask == MASK_COMPL) ? 1'b0 : alu_v;
      if (fl_mask == MASK_COMPL)
        fl_new[FLG_C] = 1'b1;
    end
  end

  // ==========================================================
  // Sequencer: the accepting cycle is the first of the count
  assign o_instr_ready = (state_r == ST_ISSUE);
  assign accept = i_ce && i_instr_valid && (state_r == ST_ISSUE);

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      state_r <= ST_ISSUE;
      wait_r  <= 3'h0;
    end else if (i_ce) begin
      unique case (state_r)
        ST_ISSUE: begin
          if (accept && cyc != CYC_ONE) begin
            state_r <= ST_WAIT;
            wait_r  <= 3'(cyc - 3'h2);
          end
        end
        ST_WAIT: begin
          if (wait_r == 3'h0)
            state_r <= ST_ISSUE;
          else
            wait_r <= 3'(wait_r - 3'h1);
        end
      endcase
    end
  end

  // Program counter moves once, at acceptance
  always_ff @(posedge i_clock) begin
    if (!i_rst_b)
      pc_r <= '0;
    else if (accept)
      pc_r <= pc_nxt;
  end
  assign o_pc = pc_r;

  // Stack strobes one cycle after acceptance
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_push_valid <= 1'b0;
      o_pop_valid  <= 1'b0;
      o_push_word  <= '0;
    end else if (i_ce) begin
      o_push_valid <= accept && push;
      o_pop_valid  <= accept && pop;
      if (accept && push)
        o_push_word <= pc_seq;
    end
  end

  // Status: execution beats a side write in the same cycle
  always_ff @(posedge i_clock) begin
    if (!i_rst_b)
      status_r <= STATUS_RST;
    else if (i_ce) begin
      if (accept) begin
        // Branches and skips carry MASK_NONE, leaving flags intact
        status_r <= (status_r & ~fl_mask) | (fl_new & fl_mask);
        if (set_i)
          status_r[FLG_I] <= 1'b1;
      end else if (i_status_we)
        status_r <= i_status_data;
    end
  end
  assign o_status_register = status_r;

  // ==========================================================
  // Register file, one process per entry; execution beats loads
  for (genvar g = 0; g < REG_NUM; g++) begin : g_reg
    always_ff @(posedge i_clock) begin
      if (!i_rst_b)
        regs_r[g] <= DATA_ZERO;
      else if (i_ce) begin
        if (accept && wr8 && i_dst_reg == 5'(g))
          regs_r[g] <= res8;
        else if (accept && wr16 && i_dst_reg == 5'(g))
          regs_r[g] <= word_sum[7:0];
        else if (accept && wr16 && rd_hi == 5'(g))
          regs_r[g] <= word_sum[15:8];
        else if (i_load_valid && i_load_reg == 5'(g))
          regs_r[g] <= i_load_data;
      end
    end
  end

  // Registered read-back for observation
  always_ff @(posedge i_clock) begin
    if (!i_rst_b)
      o_peek_data <= DATA_ZERO;
    else if (i_ce)
      o_peek_data <= regs_r[i_peek_reg];
  end
endmodule
`default_nettype wire

// ===== verif/abex_exec_sva.sv
// Concurrent checks on the ports of abex_exec.
// Assumes one clock, synchronous active-low reset, bound from the bench.
`timescale 1ns/100ps
`default_nettype none
module abex_exec_sva #(
  parameter int PC_W = 10
) (
  // Clock and reset
  input wire logic                        i_clock,
  input wire logic                        i_rst_b,
  // Instruction port
  input wire logic                        i_ce,
  input wire logic                        i_instr_valid,
  input wire abex_pkg::abex_op_e          i_op,
  input wire logic [abex_pkg::OFFS_W-1:0] i_offset,
  input wire logic                        i_status_we,
  input wire logic [PC_W-1:0]             i_pop_word,
  input wire logic                        o_instr_ready,
  input wire logic [PC_W-1:0]             o_pc,
  // Stack and status
  input wire logic                        o_push_valid,
  input wire logic [PC_W-1:0]             o_push_word,
  input wire logic                        o_pop_valid,
  input wire logic [7:0]                  o_status_register
);
  import abex_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // ==========================================================
  // Accept strobe and relative target of the op on the port
  logic            acc;
  logic [PC_W-1:0] tgt;
  assign acc = i_ce && i_instr_valid && o_instr_ready;
  assign tgt = o_pc + i_offset[PC_W-1:0] + 1'b1; // Wraps like the PC
  // ==========================================================
  // Flow control
  a_jump_target: assert property (
    acc && i_op == OP_RELATIVE_JUMP |=> !o_instr_ready && o_pc == $past(tgt)
    ##1 o_instr_ready) else $error("relative jump wrong");
  a_call_push: assert property (
    acc && i_op == OP_RELATIVE_CALL |=> !o_instr_ready && o_pc == $past(tgt)
    && o_push_valid && o_push_word == $past(o_pc) + 1'b1
    ##1 !o_instr_ready ##1 o_instr_ready) else $error("relative call wrong");
  a_ret_pop: assert property (
    acc && (i_op == OP_SUB_RETURN || i_op == OP_INTERRUPT_RETURN)
    |=> o_pop_valid && o_pc == $past(i_pop_word) && !o_instr_ready
    ##1 (!o_instr_ready)[*2] ##1 o_instr_ready) else $error("return wrong");
  a_push_pulse: assert property (
    o_push_valid |=> !o_push_valid) else $error("push not a pulse");
  a_ptr_jump: assert property (
    acc && i_op == OP_POINTER_JUMP |=> !o_instr_ready ##1 o_instr_ready)
    else $error("pointer jump length wrong");
  a_interrupt_return_enable: assert property (
    acc && i_op == OP_INTERRUPT_RETURN |-> ##[1:4] o_status_register[FLG_I])
    else $error("interrupt enable not set");
  // ==========================================================
  // Branches, flags and word-op length
  a_branch_len: assert property (
    acc && i_op >= OP_BRANCH_FLAG_SET
    |=> (o_instr_ready && o_pc == $past(o_pc) + 1'b1)
    or (!o_instr_ready && o_pc == $past(tgt) ##1 o_instr_ready))
    else $error("branch wrong");
  a_branch_flags: assert property (
    acc && i_op >= OP_BRANCH_FLAG_SET && !i_status_we
    |=> $stable(o_status_register)) else $error("branch changed flags");
  a_logic_carry: assert property (
    acc && !i_status_we && i_op inside {OP_AND, OP_AND_CONSTANT, OP_OR,
    OP_OR_CONSTANT, OP_EXCLUSIVE_OR_OP} |=> $stable(o_status_register[FLG_C]))
    else $error("logic op changed carry");
  a_word_len: assert property (
    acc && (i_op == OP_WORD_ADD_IMMEDIATE || i_op == OP_WORD_SUB_IMMEDIATE)
    |=> !o_instr_ready ##1 o_instr_ready) else $error("word op length wrong");
endmodule
`default_nettype wire

// ===== verif/abex_stack_model.sv
// Return stack standing in for the core's stack hardware.
// Assumes push and pop arrive as one-cycle pulses on i_clock.
`timescale 1ns/100ps
`default_nettype none
module abex_stack_model #(
  parameter int PW = 10
) (
  // Clock and strobes
  input  wire logic          i_clock,
  input  wire logic          i_push,
  input  wire logic [PW-1:0] i_word,
  input  wire logic          i_pop,
  // Top of stack
  output logic      [PW-1:0] o_top
);
  // ==========================================================
  // Storage; eight levels is plenty for the nesting used here
  logic [PW-1:0] mem [8];
  int            sp = 0;
  always @(posedge i_clock) begin
    if (i_push) begin
      mem[sp[2:0]] <= i_word;
      sp <= sp + 1;
    end else if (i_pop && sp > 0) begin
      sp <= sp - 1;
    end
  end
  // Empty stack shows a flipped word so a stale address never passes
  assign o_top = (sp > 0) ? mem[sp[2:0] - 3'h1] : ~mem[0];
endmodule
`default_nettype wire

// ===== verif/tb_abex_exec.sv
// Self-checking bench for abex_exec with a return-stack model.
// Assumes the checker and stack model are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
module tb_abex_exec;
  import abex_pkg::*;
  // ==========================================================
  // Design inputs and outputs
  logic i_clock = 0, i_rst_b = 0, i_ce = 1, i_instr_valid = 0;
  logic i_next_is_long = 0, i_load_valid = 0, i_status_we = 0;
  abex_op_e   i_op = OP_ADD;
  logic [4:0] i_dst_reg = 0, i_source_register = 0, i_load_reg = 0;
  logic [4:0] i_peek_reg = 0;
  logic [7:0] i_imm = 0, i_io_rdata = 0, i_load_data = 0, i_status_data = 0;
  logic [11:0] i_offset = 0;
  logic [2:0] i_bit_sel = 0;
  logic [9:0] o_pc, o_push_word, i_pop_word, p0;
  logic       o_instr_ready, o_push_valid, o_pop_valid;
  logic [7:0] o_peek_data, o_status_register, m;
  int         err_total = 0, checks_done = 0, cyc;
  localparam logic [7:0] BM [14] = '{8'h08, 8'h08, 8'h04, 8'h04, 8'h01,
    8'h01, 8'h20, 8'h20, 8'h80, 8'h80, 8'h40, 8'h40, 8'h08, 8'h08};
  always #12.5 i_clock = ~i_clock;
  abex_exec u_abex_exec (.i_clock, .i_rst_b, .i_ce, .i_instr_valid, .i_op,
    .i_dst_reg, .i_source_register, .i_imm, .i_offset, .i_bit_sel,
    .i_next_is_long, .o_instr_ready, .o_pc, .i_io_rdata, .o_push_valid,
    .o_push_word, .o_pop_valid, .i_pop_word, .i_load_valid, .i_load_reg,
    .i_load_data, .i_status_we, .i_status_data, .i_peek_reg, .o_peek_data,
    .o_status_register);
  abex_stack_model u_abex_stack_model (.i_clock, .i_push(o_push_valid),
    .i_word(o_push_word), .i_pop(o_pop_valid), .o_top(i_pop_word));
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  // Side write of a register, or of status when s is set
  task automatic side(input logic [4:0] r, input logic [7:0] d, input bit s);
    @(negedge i_clock);
    {i_load_valid, i_status_we, i_load_reg, i_load_data} = {!s, s, r, d};
    i_status_data = d;
    @(negedge i_clock);
    {i_load_valid, i_status_we} = 2'b00;
  endtask
  // Present one op, then count cycles until the port is free again
  task automatic run(input abex_op_e o, input logic [4:0] d, s,
                     input logic [11:0] k);
    @(negedge i_clock);
    i_op = o;
    {i_dst_reg, i_source_register, i_offset} = {d, s, k};
    i_imm = k[7:0];
    i_instr_valid = 1;
    p0 = o_pc;
    @(negedge i_clock);
    i_instr_valid = 0;
    cyc = 1;
    while (o_instr_ready !== 1'b1 && cyc < 9) begin
      @(negedge i_clock);
      cyc++;
    end
  endtask
  task automatic peek(input logic [4:0] r, input logic [7:0] e);
    i_peek_reg = r;
    @(negedge i_clock);
    chk(o_peek_data, e);
  endtask
  task automatic alu(input abex_op_e o, input logic [4:0] d, s,
    input logic [7:0] k, si, res, so, input int c);
    side(0, si, 1);
    run(o, d, s, {4'h0, k});
    chk(cyc, c);
    peek(d, res);
    chk(o_status_register, so);
  endtask
  task automatic fl(input abex_op_e o, input logic [4:0] d, s,
                    input logic [11:0] k, input int c, input logic [9:0] pe);
    run(o, d, s, k);
    chk(cyc, c);
    chk(o_pc, pe);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_arith;
    side(1, 8'h0f, 0);
    side(2, 8'h01, 0);
    alu(OP_ADD, 1, 2, 0, 8'h00, 8'h10, 8'h20, 1);
    alu(OP_ADD_CARRY, 1, 2, 0, 8'h01, 8'h12, 8'h00, 1);
    alu(OP_SUB_CONSTANT, 1, 0, 8'h13, 0, 8'hff, 8'h25, 1);
    alu(OP_SUB_CONST_WITH_CARRY, 1, 0, 0, 8'h25, 8'hfe, 8'h04, 1);
    alu(OP_SUB, 1, 2, 0, 8'h00, 8'hfd, 8'h04, 1);
    alu(OP_COMPARE_IMMEDIATE, 1, 0, 8'hfd, 8'h04, 8'hfd, 8'h02, 1);
  endtask
  task automatic t_word;
    side(24, 8'hff, 0);
    side(25, 8'h7f, 0);
    alu(OP_WORD_ADD_IMMEDIATE, 24, 0, 1, 0, 8'h00, 8'h0c, 2);
    peek(25, 8'h80);
    alu(OP_WORD_SUB_IMMEDIATE, 24, 0, 1, 0, 8'hff, 8'h18, 2);
    peek(25, 8'h7f);
  endtask
  task automatic t_logic;
    side(3, 8'hf0, 0);
    side(4, 8'h3c, 0);
    alu(OP_AND, 3, 4, 0, 8'h01, 8'h30, 8'h01, 1);
    alu(OP_OR_CONSTANT, 3, 0, 8'h80, 8'h01, 8'hb0, 8'h05, 1);
    alu(OP_EXCLUSIVE_OR_OP, 3, 4, 0, 8'h09, 8'h8c, 8'h05, 1);
    alu(OP_CLEAR_BITS_OP, 3, 0, 8'h0f, 8'h01, 8'h80, 8'h05, 1);
    alu(OP_ZERO_MINUS_TEST, 3, 0, 0, 8'h03, 8'h80, 8'h05, 1);
    alu(OP_ONES_COMPLEMENT, 3, 0, 0, 8'h00, 8'h7f, 8'h01, 1);
    alu(OP_TWOS_COMPLEMENT_OP, 3, 0, 0, 8'h00, 8'h81, 8'h25, 1);
  endtask
  task automatic t_flow;
    side(30, 8'h34, 0);
    side(31, 8'h01, 0);
    fl(OP_POINTER_JUMP, 0, 0, 0, 2, 10'h134);
    chk(o_status_register, 8'h25);
    fl(OP_RELATIVE_JUMP, 0, 0, 12'hffe, 2, 10'h133);
    fl(OP_RELATIVE_CALL, 0, 0, 12'h010, 3, 10'h144);
    fl(OP_SUB_RETURN, 0, 0, 0, 4, 10'h134);
    fl(OP_POINTER_CALL, 0, 0, 0, 3, 10'h134);
    side(0, 8'h00, 1);
    fl(OP_INTERRUPT_RETURN, 0, 0, 0, 4, 10'h135);
    chk(o_status_register, 8'h80);
  endtask
  // Skips past short and long instructions, and the not-taken case
  task automatic t_skip;
    {i_next_is_long, i_bit_sel, i_io_rdata} = {1'b1, 3'h1, 8'h82};
    fl(OP_COMPARE_SKIP_EQUAL, 1, 1, 0, 3, 10'h138);
    fl(OP_SKIP_IO_BIT_CLEAR, 0, 0, 0, 1, 10'h139);
    i_next_is_long = 0;
    fl(OP_COMPARE_SKIP_EQUAL, 1, 2, 0, 1, 10'h13a);
    fl(OP_SKIP_REG_BIT_CLEAR, 0, 2, 0, 2, 10'h13c);
    fl(OP_SKIP_REG_BIT_SET, 0, 2, 0, 1, 10'h13d);
    i_bit_sel = 3'h7;
    fl(OP_SKIP_IO_BIT_SET, 0, 0, 0, 2, 10'h13f);
  endtask
  // Each branch once taken backwards, once not taken
  task automatic t_branch;
    i_bit_sel = 3'h3;
    for (int i = 0; i < 14; i++) begin
      for (int t = 0; t < 2; t++) begin
        m = (((i % 2 == 0) ^ (i inside {[2:5]})) ^ t) ? BM[i] : 8'h00;
        side(0, m, 1);
        run(abex_op_e'(int'(OP_BRANCH_FLAG_SET) + i), 0, 0, 12'hffd);
        chk(cyc, t ? 1 : 2);
        chk(o_pc, t ? p0 + 10'h1 : p0 - 10'h2);
        chk(o_status_register, m);
      end
    end
  endtask
  task automatic complete_run;
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (3) @(negedge i_clock);
    i_rst_b = 1;
    t_arith;
    t_word;
    t_logic;
    t_flow;
    t_skip;
    t_branch;
    complete_run;
  end
  initial begin
    #100000;
    err_total++;
    complete_run;
  end
endmodule
bind abex_exec abex_exec_sva #(.PC_W(PC_W)) u_abex_exec_sva (.i_clock,
  .i_rst_b, .i_ce, .i_instr_valid, .i_op, .i_offset, .i_status_we,
  .i_pop_word, .o_instr_ready, .o_pc, .o_push_valid, .o_push_word,
  .o_pop_valid, .o_status_register);
`default_nettype wire
